// ---- cpu_model.sv ----
/*
 * Core-side model that calls the flash controller through its register port.
 * Assumes the bench calls its tasks one at a time from a single process.
 */
module cpu_model
(
   // Clock and read data.
   input wire logic clk,
   input wire logic [7:0] rd_data,
   // Register port request.
   output flash_ctrl_pkg::reg_req_s req
);
   import flash_ctrl_pkg::*;
   // The caller reaches the block only through this port and the clock.
   initial req = '0;
   // One write strobe; parameters are loaded before a launch.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk) req <= '0;
   endtask : wr
   // One read strobe; data is taken in the cycle after it.
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk) req <= '0;
      #1 d = rd_data;
   endtask : rd
endmodule : cpu_model

// ---- crc32_step.sv ----
/*
 * One byte step of a reflected 32-bit CRC.
 * Assumes the caller holds the running value in a register.
 */
module crc32_step
(
   // Running value and new byte.
   input wire logic [31:0] crc_in,
   input wire logic [7:0] data,
   // Updated value.
   output logic [31:0] crc_out
);
   // -------------------------------------------------------------------
   // Bitwise update
   // -------------------------------------------------------------------
   // Shifts the eight data bits through the reflected polynomial.
   function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
      begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ 32'hEDB88320) : (r >> 1);
      end
      return r;
   endfunction : step
   assign crc_out = step(crc_in, data);
endmodule : crc32_step

// ---- flash_array.sv ----
/*
 * The 8 KB program flash cell array: one write port, one registered read.
 * Assumes erase is modelled by writing the erased value byte by byte.
 */
module flash_array
(
   // Clock.
   input wire logic clk,
   // Write port.
   input wire logic we,
   input wire logic [12:0] waddr,
   input wire logic [7:0] wdata,
   // Read port, data one cycle later.
   input wire logic [12:0] raddr,
   output logic [7:0] rdata
);
   // The cells hold their contents across reset, as flash does.
   logic [7:0] mem [0:8191];
   // -------------------------------------------------------------------
   // Access
   // -------------------------------------------------------------------
   // Writes and reads happen on the same edge; a read sees old contents.
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : flash_array

// ---- flash_ctrl.sv ----
/*
 * Program flash sequencer with sector security, CRC check and boot address
 * selection. Assumes boot ROM routines drive the register port and that the
 * forced loader pin is asynchronous to clk.
 */
`include "flash_ctrl_cfg.svh"
module flash_ctrl
#(
   parameter int OP_CYCLES = `OP_CYCLES,
   parameter bit LARGE_PART = 1'b1
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Register port.
   input wire flash_ctrl_pkg::reg_req_s req,
   output logic [7:0] rd_data,
   // Code space read instruction port.
   input wire logic code_rd_req,
   input wire logic [12:0] code_rd_addr,
   output logic code_rd_valid,
   output logic code_rd_denied,
   output logic [7:0] code_rd_data,
   // Boot selection and activity.
   input wire logic force_loader_pin,
   output logic boot_valid,
   output logic [15:0] boot_addr,
   output logic busy
);
   import flash_ctrl_pkg::*;

   localparam logic [7:0] VEC_RESET = LARGE_PART ? `BOOT_VEC_LARGE : `BOOT_VEC_SMALL; // [R14]
   localparam logic [17:0] OP_LAST = 18'(OP_CYCLES - 1);
   // Common boot ROM entry; it sits above the whole flash space. [R9]
   localparam logic [15:0] ENTRY = `ENTRY_ADDR;

   ctrl_s s_q; // Registered state.
   ctrl_s s_d; // Next state.
   logic we; // Array write strobe.
   logic [12:0] waddr; // Array write address.
   logic [7:0] wdata; // Array write data.
   logic [12:0] raddr; // Array read address.
   logic [7:0] arr_q; // Array read data.
   logic [31:0] crc_next; // CRC after folding arr_q.

   // Sector index of a byte address.
   function automatic logic [2:0] sector_of(input logic [12:0] a);
      return a[12:10];
   endfunction : sector_of

   // -------------------------------------------------------------------
   // Submodules
   // -------------------------------------------------------------------
   flash_array u_array
   (
      .clk(clk),
      .we(we),
      .waddr(waddr),
      .wdata(wdata),
      .raddr(raddr),
      .rdata(arr_q)
   );
   crc32_step u_crc
   (
      .crc_in(s_q.crc),
      .data(arr_q),
      .crc_out(crc_next)
   );

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   // Register port, launch, sequencer, code reads and boot choice.
   always_comb
   begin
      logic [12:0] ea;
      logic secured;
      logic [13:0] span;
      ea = '0;
      secured = 1'b0;
      span = '0;
      s_d = s_q;
      we = 1'b0;
      waddr = s_q.base + s_q.idx[12:0];
      wdata = `ERASED_BYTE;
      raddr = code_rd_addr;
      s_d.code_valid = 1'b0;
      s_d.code_pend = 1'b0;
      // The pin passes two flip-flops before anything reads it.
      s_d.force_sync = {s_q.force_sync[0], force_loader_pin};
      // Boot address is fixed once the synchroniser has settled.
      if (!s_q.boot_valid)
      begin
         if (s_q.boot_wait == 2'h2)
         begin
            s_d.boot_valid = 1'b1;
            s_d.forced = s_q.force_sync[1];
            if (s_q.bstat != 8'h00 || s_q.force_sync[1]) // [R12] [R13]
            begin
               s_d.boot_addr = {s_q.bvec, 8'h00};
            end
            else
            begin
               s_d.boot_addr = 16'h0000; // [R11]
            end
         end
         else
         begin
            s_d.boot_wait = s_q.boot_wait + 2'h1;
         end
      end
      // Register reads answer in the next cycle; unmapped reads give zero.
      if (req.rd)
      begin
         case (req.addr)
            `OFS_CMD: s_d.rdata = {4'h0, s_q.cmd};
            `OFS_ADDR_LO: s_d.rdata = s_q.addr[7:0];
            `OFS_ADDR_HI: s_d.rdata = {3'h0, s_q.addr[12:8]};
            `OFS_STATUS: s_d.rdata = {3'h0, s_q.forced, s_q.loader_ok, s_q.reject, s_q.done,
                                      s_q.st != ST_IDLE};
            `OFS_SECURITY: s_d.rdata = s_q.sec;
            `OFS_BOOT_VEC: s_d.rdata = s_q.bvec;
            `OFS_BOOT_STAT: s_d.rdata = s_q.bstat;
            `OFS_UCFG: s_d.rdata = s_q.ucfg;
            4'h9: s_d.rdata = s_q.crc[7:0];
            4'hA: s_d.rdata = s_q.crc[15:8];
            4'hB: s_d.rdata = s_q.crc[23:16];
            4'hC: s_d.rdata = s_q.crc[31:24];
            `OFS_CFG_VAL: s_d.rdata = s_q.cfgval;
            default: s_d.rdata = 8'h00;
         endcase
      end
      // Register writes; parameter writes are ignored while busy.
      if (req.wr && s_q.st == ST_IDLE) // [R19]
      begin
         case (req.addr)
            `OFS_ADDR_LO: s_d.addr[7:0] = req.wdata;
            `OFS_ADDR_HI: s_d.addr[12:8] = req.wdata[4:0];
            `OFS_CFG_VAL: s_d.cfgval = req.wdata;
            `OFS_DATA:
            begin
               // Loads the page buffer and steps through the page.
               s_d.pbuf[s_q.addr[5:0]] = req.wdata; // [R4]
               s_d.pvalid[s_q.addr[5:0]] = 1'b1;
               s_d.addr[5:0] = s_q.addr[5:0] + 6'h01;
            end
            default:
            begin
            end
         endcase
      end
      // Writing ones to the status register clears the done and reject flags.
      if (req.wr && req.addr == `OFS_STATUS)
      begin
         if (req.wdata[`STAT_DONE])
         begin
            s_d.done = 1'b0;
         end
         if (req.wdata[`STAT_REJECT])
         begin
            s_d.reject = 1'b0;
         end
      end
      // Operation launch from the command register.
      if (req.wr && req.addr == `OFS_CMD && s_q.st == ST_IDLE)
      begin
         ea = s_q.addr;
         secured = s_q.sec[sector_of(ea)];
         s_d.cmd = cmd_e'(req.wdata[3:0]);
         s_d.idx = '0;
         s_d.timer = '0;
         s_d.pend = 1'b0;
         s_d.st = ST_WAIT;
         s_d.done = 1'b0;
         case (cmd_e'(req.wdata[3:0]))
            CMD_PROG_PAGE, CMD_ERASE_BYTE, CMD_ERASE_PAGE, CMD_ERASE_SECTOR:
            begin
               if (secured) // [R20]
               begin
                  s_d.reject = 1'b1;
                  s_d.st = ST_IDLE;
               end
               else
               begin
                  s_d.st = ST_EXEC;
                  case (cmd_e'(req.wdata[3:0]))
                     CMD_ERASE_BYTE:
                     begin
                        s_d.base = ea; // [R2]
                        span = 14'h0001;
                     end
                     CMD_ERASE_SECTOR:
                     begin
                        s_d.base = {ea[12:10], 10'h000}; // [R1] [R3]
                        span = `SECTOR_BYTES;
                     end
                     default:
                     begin
                        s_d.base = {ea[12:6], 6'h00}; // [R1] [R3]
                        span = `PAGE_BYTES;
                     end
                  endcase
               end
            end
            CMD_ERASE_CHIP:
            begin
               // Chip erase is always allowed and lifts all sector security.
               s_d.st = ST_EXEC;
               s_d.base = '0; // [R3] [R20]
               span = `CHIP_BYTES;
               s_d.sec = 8'h00;
            end
            CMD_CRC_SECTOR:
            begin
               s_d.st = ST_EXEC;
               s_d.base = {ea[12:10], 10'h000}; // [R8]
               span = `SECTOR_BYTES;
               s_d.crc = `CRC_INIT;
            end
            CMD_CRC_ALL:
            begin
               s_d.st = ST_EXEC;
               s_d.base = '0; // [R8]
               span = `CHIP_BYTES;
               s_d.crc = `CRC_INIT;
            end
            CMD_SECURE:
            begin
               s_d.sec[sector_of(ea)] = 1'b1; // [R6]
            end
            CMD_WRITE_CFG:
            begin
               // Rewrites a boot or configuration element chosen by the address.
               case (ea[1:0])
                  2'h0: s_d.ucfg = s_q.cfgval; // [R16]
                  2'h1: s_d.bstat = s_q.cfgval; // [R16] [R18]
                  default: s_d.bvec = s_q.cfgval; // [R16]
               endcase
            end
            CMD_CLEAR_BUF:
            begin
               s_d.pvalid = '0;
            end
            default:
            begin
               s_d.st = ST_IDLE;
            end
         endcase
         s_d.cnt = span;
         // Erasing into the top 512 bytes removes the shipped loader.
         if (s_d.st == ST_EXEC && req.wdata[3:0] != 4'h1 && req.wdata[3:0] != 4'h6 &&
             req.wdata[3:0] != 4'h7 && ({1'b0, s_d.base} + span) > `LOADER_BASE)
         begin
            s_d.loader_ok = 1'b0; // [R15]
         end
      end
      // Sequencer: one byte per cycle, then wait out the fixed time.
      case (s_q.st)
         ST_IDLE:
         begin
            // Code reads are served only while idle and only from open sectors.
            if (code_rd_req)
            begin
               s_d.code_pend = 1'b1;
               s_d.code_deny_pend = s_q.sec[sector_of(code_rd_addr)]; // [R7]
            end
         end
         ST_EXEC, ST_WAIT:
         begin
            s_d.timer = s_q.timer + 18'h1; // [R5]
            if (code_rd_req)
            begin
               s_d.code_pend = 1'b1;
               s_d.code_deny_pend = 1'b1; // [R19]
            end
            if (s_q.st == ST_EXEC)
            begin
               raddr = waddr;
               if (s_q.idx != s_q.cnt)
               begin
                  s_d.idx = s_q.idx + 14'h1;
                  if (s_q.cmd == CMD_CRC_SECTOR || s_q.cmd == CMD_CRC_ALL)
                  begin
                     s_d.pend = 1'b1;
                  end
                  else
                  begin
                     we = (s_q.cmd != CMD_PROG_PAGE) || s_q.pvalid[s_q.idx[5:0]]; // [R4]
                     wdata = (s_q.cmd == CMD_PROG_PAGE) ? s_q.pbuf[s_q.idx[5:0]] : `ERASED_BYTE;
                  end
               end
               else
               begin
                  s_d.pend = 1'b0;
               end
               if (s_q.pend)
               begin
                  s_d.crc = crc_next; // [R8]
               end
               if (s_q.idx == s_q.cnt && !s_q.pend)
               begin
                  s_d.st = ST_WAIT;
               end
            end
            else if (s_q.timer >= OP_LAST)
            begin
               s_d.st = ST_IDLE; // [R5] [R19]
               s_d.done = 1'b1;
               if (s_q.cmd == CMD_PROG_PAGE)
               begin
                  s_d.pvalid = '0;
               end
            end
         end
         default:
         begin
            s_d.st = ST_IDLE;
         end
      endcase
      // A code read answers two cycles after it was asked for.
      if (s_q.code_pend)
      begin
         s_d.code_valid = 1'b1;
         s_d.code_denied = s_q.code_deny_pend;
         s_d.code_data = s_q.code_deny_pend ? 8'h00 : arr_q; // [R7]
      end
      // Busy is registered so that the output comes straight from a flip-flop.
      s_d.busy = (s_d.st != ST_IDLE); // [R19]
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------
   // Reset loads factory boot settings and an empty page buffer.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_q <= '0;
         s_q.bvec <= VEC_RESET; // [R14]
         s_q.bstat <= `BOOT_STAT_RESET;
         s_q.ucfg <= `UCFG_RESET;
         s_q.loader_ok <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign rd_data = s_q.rdata;
   assign code_rd_valid = s_q.code_valid;
   assign code_rd_denied = s_q.code_denied;
   assign code_rd_data = s_q.code_data;
   assign boot_valid = s_q.boot_valid;
   assign boot_addr = s_q.boot_addr;
   assign busy = s_q.busy;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   sequence s_launch;
      req.wr && req.addr == `OFS_CMD && !busy;
   endsequence
   sequence s_code_ask;
      code_rd_req && !busy;
   endsequence
   property p_secured_read;
      @(posedge clk) disable iff (!rst_b)
      s_code_ask and (s_q.sec[code_rd_addr[12:10]] == 1'b1) |-> ##2 code_rd_denied;
   endproperty
   a_secured_read: assert property (p_secured_read) else $error("secured read served"); // [R7]
   property p_open_read;
      @(posedge clk) disable iff (!rst_b)
      s_code_ask and (s_q.sec[code_rd_addr[12:10]] == 1'b0) |-> ##2 code_rd_valid && !code_rd_denied;
   endproperty
   a_open_read: assert property (p_open_read) else $error("open read denied"); // [R7]
   property p_reject;
      @(posedge clk) disable iff (!rst_b)
      s_launch and (req.wdata[3:0] >= 4'h1 && req.wdata[3:0] <= 4'h4) and
      s_q.sec[s_q.addr[12:10]] |=> s_q.reject && !busy;
   endproperty
   a_reject: assert property (p_reject) else $error("secured erase not rejected"); // [R20]
   property p_busy_start;
      @(posedge clk) disable iff (!rst_b)
      s_launch and (req.wdata[3:0] == 4'h7) |=> busy [*8];
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("busy dropped early"); // [R19]
   property p_op_bound;
      @(posedge clk) disable iff (!rst_b)
      busy |-> s_q.timer <= 18'(OP_CYCLES);
   endproperty
   a_op_bound: assert property (p_op_bound) else $error("operation overran"); // [R5]
   property p_zero_boot;
      @(posedge clk) disable iff (!rst_b)
      $rose(boot_valid) && !s_q.forced && s_q.bstat == 8'h00 |-> boot_addr == 16'h0000;
   endproperty
   a_zero_boot: assert property (p_zero_boot) else $error("zero flag not at 0000"); // [R11]
   property p_vec_boot;
      @(posedge clk) disable iff (!rst_b)
      $rose(boot_valid) && (s_q.forced || s_q.bstat != 8'h00) |-> boot_addr == {s_q.bvec, 8'h00};
   endproperty
   a_vec_boot: assert property (p_vec_boot) else $error("vector start wrong"); // [R12] [R13]
   property p_chip_unsecure;
      @(posedge clk) disable iff (!rst_b)
      s_launch and (req.wdata[3:0] == 4'h5) |=> s_q.sec == 8'h00 && busy;
   endproperty
   a_chip_unsecure: assert property (p_chip_unsecure) else $error("chip erase refused"); // [R20]
   property p_ignore_busy;
      @(posedge clk) disable iff (!rst_b)
      busy && req.wr && req.addr == `OFS_CMD |=> s_q.cmd == $past(s_q.cmd);
   endproperty
   a_ignore_busy: assert property (p_ignore_busy) else $error("command taken while busy"); // [R19]
endmodule : flash_ctrl

// ---- flash_ctrl_cfg.svh ----
/*
 * Constants of the program flash controller: register offsets, status fields,
 * reset values and operation timing.
 * Assumes a 125 MHz system clock and an 8-bit register port.
 */
// Function
// R1: Eight 1 KB sectors, 64-byte pages.
// R2: Byte-level read, erase and write.
// R3: Sector, page and whole chip erase.
// R4: Page buffer programs 1 to 64 bytes.
// R5: Internal timing, every operation within 2 ms.
// R6: Separate security bit per sector.
// R7: Code reads of secured sectors refused.
// R8: No readback; 32-bit CRC of sector/all.
// R9: Boot ROM entry sits at FF00H.
// R10: Caller loads parameters before calling entry.
// R11: Zero boot flag starts at 0000H.
// R12: Nonzero flag starts at vector, low 00H.
// R13: Forced loader mode acts as nonzero flag.
// R14: Vector ships as 1EH or 0EH.
// R15: Loader ships in top 512 bytes.
// R16: Config byte, flag and vector are rewritable.
// R17: Loader uses supply, ground, serial, reset.
// R18: Programmer clears boot flag when done.
// R19: Busy during operations, new requests ignored.
// R20: Secured sector edits rejected except chip erase.
`ifndef FLASH_CTRL_CFG_SVH
`define FLASH_CTRL_CFG_SVH
// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define OFS_CMD 4'h0
`define OFS_ADDR_LO 4'h1
`define OFS_ADDR_HI 4'h2
`define OFS_DATA 4'h3
`define OFS_STATUS 4'h4
`define OFS_SECURITY 4'h5
`define OFS_BOOT_VEC 4'h6
`define OFS_BOOT_STAT 4'h7
`define OFS_UCFG 4'h8
`define OFS_CRC0 4'h9
`define OFS_CFG_VAL 4'hD
// ---------------------------------------------------------------------
// Status fields and values
// ---------------------------------------------------------------------
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_REJECT 2
`define STAT_LOADER 3
`define STAT_FORCED 4
`define ERASED_BYTE 8'hFF
`define BOOT_VEC_LARGE 8'h1E
`define BOOT_VEC_SMALL 8'h0E
`define BOOT_STAT_RESET 8'h01
`define UCFG_RESET 8'h00
`define ENTRY_ADDR 16'hFF00
`define LOADER_BASE 14'h1E00
`define PAGE_BYTES 14'h0040
`define SECTOR_BYTES 14'h0400
`define CHIP_BYTES 14'h2000
`define CRC_INIT 32'hFFFFFFFF
// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define OP_TIME_NS 2000000
`define CLK_PERIOD_NS 8
`define OP_CYCLES (`OP_TIME_NS / `CLK_PERIOD_NS)
`endif

// ---- flash_ctrl_pkg.sv ----
/*
 * Types of the program flash controller.
 * Assumes the constants header is on the include path.
 */
package flash_ctrl_pkg;
   // -------------------------------------------------------------------
   // Sequencer states and commands
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_WAIT = 2'b10} state_e;
   typedef enum logic [3:0] {
      CMD_NONE = 4'h0, CMD_PROG_PAGE = 4'h1, CMD_ERASE_BYTE = 4'h2, CMD_ERASE_PAGE = 4'h3,
      CMD_ERASE_SECTOR = 4'h4, CMD_ERASE_CHIP = 4'h5, CMD_CRC_SECTOR = 4'h6,
      CMD_CRC_ALL = 4'h7, CMD_SECURE = 4'h8, CMD_WRITE_CFG = 4'h9, CMD_CLEAR_BUF = 4'hA
   } cmd_e;
   // Register port request.
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;
   // Whole controller state.
   typedef struct packed {
      state_e st;
      logic busy; // Registered copy of st != ST_IDLE.
      cmd_e cmd;
      logic [12:0] addr;
      logic [63:0][7:0] pbuf;
      logic [63:0] pvalid;
      logic [13:0] idx;
      logic [13:0] cnt;
      logic [12:0] base;
      logic [17:0] timer;
      logic pend;
      logic [7:0] sec;
      logic [7:0] bvec;
      logic [7:0] bstat;
      logic [7:0] ucfg;
      logic [7:0] cfgval;
      logic [31:0] crc;
      logic done;
      logic reject;
      logic loader_ok;
      logic [1:0] force_sync;
      logic forced;
      logic [1:0] boot_wait;
      logic boot_valid;
      logic [15:0] boot_addr;
      logic [7:0] rdata;
      logic code_pend;
      logic code_deny_pend;
      logic code_valid;
      logic code_denied;
      logic [7:0] code_data;
   } ctrl_s;
endpackage : flash_ctrl_pkg

// ---- flash_program_memory_boot_ctrl_bench.sv ----
/*
 * Self-checking bench of the flash controller.
 * Assumes a shortened operation time so the run stays short.
 */
`include "flash_ctrl_cfg.svh"
module flash_program_memory_boot_ctrl_bench;
   import flash_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OP = 9000;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic code_rd_req = 1'b0;
   logic [12:0] code_rd_addr = 13'h0000;
   logic force_loader_pin = 1'b0;
   reg_req_s req;
   logic [7:0] rd_data, code_rd_data, v;
   logic code_rd_valid, code_rd_denied, boot_valid, busy;
   logic [15:0] boot_addr;
   logic [31:0] crc;
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   // Reset values and an unmapped offset, as offset beside expected byte.
   localparam logic [11:0] ROWS [6] = '{{`OFS_BOOT_VEC, `BOOT_VEC_LARGE},
      {`OFS_BOOT_STAT, `BOOT_STAT_RESET}, {`OFS_UCFG, `UCFG_RESET},
      {`OFS_SECURITY, 8'h00}, {`OFS_STATUS, 8'h08}, {4'hE, 8'h00}};
   always #4 clk = ~clk;
   flash_ctrl #(.OP_CYCLES(OP), .LARGE_PART(1'b1)) flash_ctrl_i (.clk(clk), .rst_b(rst_b),
      .req(req), .rd_data(rd_data), .code_rd_req(code_rd_req), .code_rd_addr(code_rd_addr),
      .code_rd_valid(code_rd_valid), .code_rd_denied(code_rd_denied),
      .code_rd_data(code_rd_data), .force_loader_pin(force_loader_pin),
      .boot_valid(boot_valid), .boot_addr(boot_addr), .busy(busy));
   cpu_model cpu_model_i (.clk(clk), .rd_data(rd_data), .req(req));
   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   // Compares one value against its expectation.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Issues one code read and checks the answer in the cycle that it stands.
   task automatic code_rd(input logic [12:0] a, input logic den, input logic [7:0] d);
      @(posedge clk)
      begin
         code_rd_req <= 1'b1;
         code_rd_addr <= a;
      end
      @(posedge clk) code_rd_req <= 1'b0;
      @(posedge clk);
      #1 chk({code_rd_valid, code_rd_denied, code_rd_data}, {1'b1, den, d});
   endtask : code_rd
   // Launches a command and waits for busy to drop within the op time.
   task automatic run(input logic [3:0] c);
      int k;
      k = 0;
      cpu_model_i.wr(`OFS_CMD, {4'h0, c});
      #1 chk(busy, 1);
      while (busy === 1'b1 && k < OP + 50)
      begin
         @(posedge clk);
         #1 k++;
      end
      chk(k <= OP + 1, 1);
   endtask : run
   // Expected CRC of a run of erased bytes.
   function automatic logic [31:0] crc_ff(input int n);
      logic [31:0] c;
      c = 32'hFFFFFFFF;
      for (int i = 0; i < n; i++)
      begin
         c = c ^ 32'h000000FF;
         for (int b = 0; b < 8; b++)
            c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
      end
      return c;
   endfunction : crc_ff
   // Reads the four CRC bytes, least significant first.
   task automatic rd_crc(output logic [31:0] c);
      logic [7:0] b;
      for (int i = 0; i < 4; i++)
      begin
         cpu_model_i.rd(`OFS_CRC0 + 4'(i), b);
         c[8 * i +: 8] = b;
      end
   endtask : rd_crc
   // Cuts a hung run short.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 85000)
      begin
         n_mismatch++;
         finish_test();
      end
   end
   // Main sequence.
   initial
   begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk({boot_valid, boot_addr}, {1'b1, 16'h1E00});
      foreach (ROWS[i])
      begin
         cpu_model_i.rd(ROWS[i][11:8], v);
         chk(v, ROWS[i][7:0]);
      end
      cpu_model_i.wr(`OFS_ADDR_HI, 8'h00);
      cpu_model_i.wr(`OFS_ADDR_LO, 8'h40);
      cpu_model_i.wr(`OFS_DATA, 8'hA5);
      cpu_model_i.wr(`OFS_DATA, 8'h5A);
      cpu_model_i.wr(`OFS_DATA, 8'h3C);
      cpu_model_i.wr(`OFS_CMD, 8'h01);
      code_rd(13'h0040, 1'b1, 8'h00);
      run(4'h0);
      code_rd(13'h0040, 1'b0, 8'hA5);
      code_rd(13'h0042, 1'b0, 8'h3C);
      cpu_model_i.wr(`OFS_ADDR_LO, 8'h41);
      run(4'h2);
      code_rd(13'h0041, 1'b0, 8'hFF);
      code_rd(13'h0042, 1'b0, 8'h3C);
      run(4'h4);
      code_rd(13'h0042, 1'b0, 8'hFF);
      run(4'h8);
      cpu_model_i.rd(`OFS_SECURITY, v);
      chk(v, 8'h01);
      code_rd(13'h0041, 1'b1, 8'h00);
      cpu_model_i.wr(`OFS_CMD, 8'h03);
      #1 chk(busy, 0);
      cpu_model_i.rd(`OFS_STATUS, v);
      chk(v[2], 1);
      cpu_model_i.wr(`OFS_STATUS, 8'h06);
      cpu_model_i.wr(`OFS_CFG_VAL, 8'h00);
      cpu_model_i.wr(`OFS_ADDR_LO, 8'h01);
      run(4'h9);
      cpu_model_i.rd(`OFS_BOOT_STAT, v);
      chk(v, 8'h00);
      run(4'h5);
      run(4'h7);
      rd_crc(crc);
      chk(crc, crc_ff(8192));
      cpu_model_i.rd(`OFS_STATUS, v);
      chk(v, 8'h02);
      run(4'h6);
      rd_crc(crc);
      chk(crc, crc_ff(1024));
      @(posedge clk);
      force_loader_pin <= 1'b1;
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk(boot_addr, 16'h1E00);
      cpu_model_i.rd(`OFS_STATUS, v);
      chk(v[4], 1);
      finish_test();
   end
endmodule : flash_program_memory_boot_ctrl_bench
